// ### design/psc_pkg.sv
// constants and carrier types for the pseudo-static memory host controller
// assumes a single 100 MHz clock domain; all times are converted to cycles here
package psc_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int CLK_NS = 10;
    localparam int T_PWRUP_NS = 200000;
    localparam int T_RC_NS = 100;
    localparam int T_WP_FAST_NS = 70;
    localparam int T_WC_FAST_NS = 100;
    localparam int T_WP_SLOW_NS = 100;
    localparam int T_WC_SLOW_NS = 110;
    localparam int T_RUN_NS = 4000;

    // least times round up
    localparam int PWRUP_CYC = (T_PWRUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RC_CYC = (T_RC_NS + CLK_NS - 1) / CLK_NS;
    localparam int WP_FAST_CYC = (T_WP_FAST_NS + CLK_NS - 1) / CLK_NS;
    localparam int WC_FAST_CYC = (T_WC_FAST_NS + CLK_NS - 1) / CLK_NS;
    localparam int WP_SLOW_CYC = (T_WP_SLOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int WC_SLOW_CYC = (T_WC_SLOW_NS + CLK_NS - 1) / CLK_NS;
    // longest time rounds down
    localparam int RUN_CYC = T_RUN_NS / CLK_NS;

    localparam int SYNC_CYC = 2;
    // pin register lag, synchroniser and capture slack on top of the access time
    localparam int RD_LEN = RC_CYC + SYNC_CYC + 3;
    localparam int FAST_WR_MAX = 20;
    localparam int DUMMY_READS = 2;
    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;

    // ************************************************************
    // reset values of the pins
    // ************************************************************
    localparam logic PIN_IDLE = 1'h1;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [6:0] {
        S_PWRUP = 7'h01,
        S_DUMMY = 7'h02,
        S_IDLE  = 7'h04,
        S_READ  = 7'h08,
        S_WRITE = 7'h10,
        S_BREAK = 7'h20,
        S_SLEEP = 7'h40
    } psc_state_t;

    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [1:0] be;
    } psc_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic cs_n;
        logic we_n;
        logic oe_n;
        logic upper_byte_n;
        logic lower_byte_n;
        logic sleep_n;
    } psc_pins_t;

endpackage

// ### design/psc_write_guard.sv
// tracks runs of consecutive writes for the memory host controller
// assumes start and clear pulses come from logic on the same clock
module psc_write_guard #(
    parameter int FAST_MAX = psc_pkg::FAST_WR_MAX,
    parameter int RUN_MAX = psc_pkg::RUN_CYC
) (
    input wire logic clk,       // system clock
    input wire logic rst_b,     // async reset, active low
    input wire logic wr_start,  // pulse: a write begins
    input wire logic run_clear, // pulse: read done or long chip-select gap
    output logic slow,          // use the continuous-write timing
    output logic need_break     // run is close to the refresh limit
);

    logic [7:0] wr_count;
    logic [15:0] run_cnt;

    // ************************************************************
    // write count within the run
    // ************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_count <= 8'h00;
        end else if (run_clear) begin
            wr_count <= 8'h00;
        end else if (wr_start && wr_count != 8'hFF) begin
            wr_count <= wr_count + 8'h01;
        end
    end

    // ************************************************************
    // elapsed run time
    // ************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            run_cnt <= 16'h0000;
        end else if (run_clear) begin
            run_cnt <= 16'h0000;
        end else if (wr_count != 8'h00 && run_cnt != 16'hFFFF) begin
            run_cnt <= run_cnt + 16'h0001;
        end
    end

    // 21st and later writes of a run take the slow set
    assign slow = (32'(wr_count) >= 32'(FAST_MAX));
    // leave room for one more slow write before the limit
    assign need_break = (32'(run_cnt) >= 32'(RUN_MAX - psc_pkg::WC_SLOW_CYC));

endmodule

// ### design/psc_host.sv
// host-side controller driving an asynchronous 16-bit pseudo-static memory
// assumes the data bus pin input is asynchronous; user requests are on CLK
module psc_host #(
    parameter int PWRUP_CYCLES = psc_pkg::PWRUP_CYC
) (
    input wire logic CLK,                               // 100 MHz clock
    input wire logic RST_B,                             // async reset
    input wire psc_pkg::psc_req_t REQ,                  // request fields
    input wire logic REQ_VALID,                         // request present
    output logic REQ_READY,                             // request taken
    output logic [psc_pkg::DATA_W-1:0] RSP_RDATA,       // read data
    output logic RSP_VALID,                             // access done pulse
    output logic INIT_DONE,                             // init finished
    input wire logic SLEEP_REQ,                         // ask for power-down
    output psc_pkg::psc_pins_t MEM,                     // memory control pins
    input wire logic [psc_pkg::DATA_W-1:0] MEM_DQ_I,    // data pin level
    output logic [psc_pkg::DATA_W-1:0] MEM_DQ_O,        // data pin drive
    output logic MEM_DQ_OE_N                            // low drives data
);

    psc_pkg::psc_state_t state;
    psc_pkg::psc_state_t next_state;
    logic [31:0] cnt;
    logic [1:0] dummy_cnt;
    logic [31:0] gap_cnt;
    logic slow;
    logic need_break;
    logic wr_slow;
    logic wr_start;
    logic run_clear;
    logic last;
    logic [psc_pkg::ADDR_W-1:0] addr;
    logic [psc_pkg::DATA_W-1:0] wdata;
    logic [1:0] be;
    logic [psc_pkg::DATA_W-1:0] dq_s1;
    logic [psc_pkg::DATA_W-1:0] dq_s2;
    logic take;

    localparam logic PIN_IDLE_C = psc_pkg::PIN_IDLE;

    function automatic logic [31:0] wp_len(input logic s);
        wp_len = s ? 32'(psc_pkg::WP_SLOW_CYC) : 32'(psc_pkg::WP_FAST_CYC);
    endfunction

    function automatic logic [31:0] wc_len(input logic s);
        wc_len = s ? 32'(psc_pkg::WC_SLOW_CYC) : 32'(psc_pkg::WC_FAST_CYC);
    endfunction

    // ************************************************************
    // request acceptance
    // ************************************************************
    assign REQ_READY = (state == psc_pkg::S_IDLE) && !need_break && !SLEEP_REQ;
    assign take = REQ_READY && REQ_VALID;
    assign wr_start = take && REQ.write;

    always_comb begin
        case (state)
            psc_pkg::S_PWRUP: last = (cnt == 32'(PWRUP_CYCLES - 1));
            psc_pkg::S_DUMMY, psc_pkg::S_READ: last = (cnt == 32'(psc_pkg::RD_LEN - 1));
            psc_pkg::S_WRITE: last = (cnt == wc_len(wr_slow) - 32'h0000_0001);
            psc_pkg::S_BREAK: last = (cnt == 32'(psc_pkg::RC_CYC - 1));
            default: last = 1'b0;
        endcase
    end

    // ************************************************************
    // state sequencing
    // ************************************************************
    always_comb begin
        next_state = state;
        case (state)
            psc_pkg::S_PWRUP: begin
                if (last) begin
                    next_state = psc_pkg::S_DUMMY;
                end
            end
            psc_pkg::S_DUMMY: begin
                if (last && dummy_cnt == 2'(psc_pkg::DUMMY_READS - 1)) begin
                    next_state = psc_pkg::S_IDLE;
                end
            end
            psc_pkg::S_IDLE: begin
                if (need_break) begin
                    next_state = psc_pkg::S_BREAK;
                end else if (SLEEP_REQ) begin
                    next_state = psc_pkg::S_SLEEP;
                end else if (take) begin
                    next_state = REQ.write ? psc_pkg::S_WRITE : psc_pkg::S_READ;
                end
            end
            psc_pkg::S_READ, psc_pkg::S_WRITE, psc_pkg::S_BREAK: begin
                if (last) begin
                    next_state = psc_pkg::S_IDLE;
                end
            end
            psc_pkg::S_SLEEP: begin
                if (!SLEEP_REQ) begin
                    next_state = psc_pkg::S_PWRUP;
                end
            end
            default: next_state = psc_pkg::S_PWRUP;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state <= psc_pkg::S_PWRUP;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            cnt <= 32'h0000_0000;
        end else if (next_state != state || last) begin
            cnt <= 32'h0000_0000;
        end else if (state != psc_pkg::S_IDLE && state != psc_pkg::S_SLEEP) begin
            cnt <= cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            dummy_cnt <= 2'h0;
        end else if (state == psc_pkg::S_PWRUP) begin
            dummy_cnt <= 2'h0;
        end else if (state == psc_pkg::S_DUMMY && last) begin
            dummy_cnt <= dummy_cnt + 2'h1;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            INIT_DONE <= 1'b0;
        end else if (state == psc_pkg::S_DUMMY && next_state == psc_pkg::S_IDLE) begin
            INIT_DONE <= 1'b1;
        end else if (state == psc_pkg::S_SLEEP) begin
            INIT_DONE <= 1'b0;
        end
    end

    // ************************************************************
    // write run tracking
    // ************************************************************
    // idle time with chip select high also lets hidden refresh catch up
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            gap_cnt <= 32'h0000_0000;
        end else if (state != psc_pkg::S_IDLE || run_clear) begin
            gap_cnt <= 32'h0000_0000;
        end else begin
            gap_cnt <= gap_cnt + 32'h0000_0001;
        end
    end

    assign run_clear = (state == psc_pkg::S_READ && last) || (state == psc_pkg::S_BREAK && last)
        || (gap_cnt == 32'(psc_pkg::RC_CYC - 1));

    psc_write_guard u_guard (
        .clk(CLK),
        .rst_b(RST_B),
        .wr_start(wr_start),
        .run_clear(run_clear),
        .slow(slow),
        .need_break(need_break)
    );

    // ************************************************************
    // latched request
    // ************************************************************
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            addr <= '0;
            wdata <= '0;
            be <= 2'h0;
            wr_slow <= 1'b0;
        end else if (take) begin
            addr <= REQ.addr;
            wdata <= REQ.wdata;
            be <= REQ.be;
            wr_slow <= slow;
        end
    end

    // ************************************************************
    // memory pins
    // ************************************************************
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            MEM <= '{addr: '0, cs_n: PIN_IDLE_C, we_n: PIN_IDLE_C, oe_n: PIN_IDLE_C,
                     upper_byte_n: PIN_IDLE_C, lower_byte_n: PIN_IDLE_C, sleep_n: PIN_IDLE_C};
            MEM_DQ_OE_N <= 1'b1;
            MEM_DQ_O <= '0;
        end else begin
            MEM.addr <= (state == psc_pkg::S_DUMMY) ? '0 : addr;
            MEM.sleep_n <= (state != psc_pkg::S_SLEEP);
            case (state)
                psc_pkg::S_DUMMY, psc_pkg::S_READ: begin
                    // full cycle with a stable address, chip select high on the last count
                    MEM.cs_n <= (cnt >= 32'(psc_pkg::RD_LEN - 1));
                    MEM.oe_n <= (cnt >= 32'(psc_pkg::RD_LEN - 1));
                    MEM.we_n <= 1'b1;
                    MEM.upper_byte_n <= (state == psc_pkg::S_DUMMY) ? 1'b0 : !be[1];
                    MEM.lower_byte_n <= (state == psc_pkg::S_DUMMY) ? 1'b0 : !be[0];
                    MEM_DQ_OE_N <= 1'b1;
                end
                psc_pkg::S_WRITE: begin
                    // select and strobe fall and rise together
                    MEM.cs_n <= (cnt >= wp_len(wr_slow));
                    MEM.we_n <= (cnt >= wp_len(wr_slow));
                    MEM.oe_n <= 1'b1;
                    MEM.upper_byte_n <= !be[1];
                    MEM.lower_byte_n <= !be[0];
                    MEM_DQ_OE_N <= 1'b0;
                    MEM_DQ_O <= wdata;
                end
                default: begin
                    // chip select high during power-up, gaps and sleep
                    MEM.cs_n <= 1'b1;
                    MEM.we_n <= 1'b1;
                    MEM.oe_n <= 1'b1;
                    MEM.upper_byte_n <= 1'b1;
                    MEM.lower_byte_n <= 1'b1;
                    MEM_DQ_OE_N <= 1'b1;
                end
            endcase
        end
    end

    // ************************************************************
    // read data capture and completion
    // ************************************************************
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            dq_s1 <= '0;
            dq_s2 <= '0;
        end else begin
            dq_s1 <= MEM_DQ_I;
            dq_s2 <= dq_s1;
        end
    end

    // sample while chip select is still low on the pin; no wait from the device
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            RSP_RDATA <= '0;
        end else if (state == psc_pkg::S_READ && cnt == 32'(psc_pkg::RD_LEN - 2)) begin
            RSP_RDATA <= dq_s2;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            RSP_VALID <= 1'b0;
        end else begin
            RSP_VALID <= last && (state == psc_pkg::S_READ || state == psc_pkg::S_WRITE);
        end
    end

endmodule

// ### sim/psc_host_assertions.sv
// pin-level checker for the memory host controller
// assumes it is bound to psc_host and sees only its ports
module psc_host_assertions #(
    parameter int PWRUP_CYCLES = 20
) (
    input wire logic CLK, // clock
    input wire logic RST_B, // reset, active low
    input wire psc_pkg::psc_req_t REQ, // request fields
    input wire logic REQ_VALID, // request present
    input wire logic REQ_READY, // request taken
    input wire logic INIT_DONE, // init finished
    input wire psc_pkg::psc_pins_t MEM // memory pins
);
    logic [1:0] last_be;
    logic [1:0] rd_cnt;
    logic [3:0] gap_cnt;
    logic [9:0] run_cnt;
    int up_cnt;
    logic cs_q;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // ********
    // helper counters
    // ********
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            last_be <= 2'h3;
            up_cnt <= 0;
            rd_cnt <= 2'h0;
            cs_q <= 1'h1;
        end else if (!MEM.sleep_n) begin
            last_be <= 2'h3;
            up_cnt <= 0;
            rd_cnt <= 2'h0;
            cs_q <= 1'h1;
        end else begin
            cs_q <= MEM.cs_n;
            if (REQ_VALID && REQ_READY) last_be <= REQ.be;
            if (up_cnt <= PWRUP_CYCLES) up_cnt <= up_cnt + 1;
            if (cs_q && !MEM.cs_n && MEM.we_n && rd_cnt != 2'h3) rd_cnt <= rd_cnt + 2'h1;
        end
    end
    // write run length, cleared by a read or a long chip-select gap
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            gap_cnt <= 4'h0;
            run_cnt <= 10'h000;
        end else begin
            gap_cnt <= !MEM.cs_n ? 4'h0 : gap_cnt + {3'h0, gap_cnt != 4'hF};
            if (!MEM.oe_n || (MEM.cs_n && gap_cnt >= 4'h9)) run_cnt <= 10'h000;
            else if ((!MEM.cs_n || run_cnt != 10'h000) && run_cnt != 10'h3FF) run_cnt <= run_cnt + 10'h001;
        end
    end
    // ********
    // assertions
    // ********
    sequence s_rd_start;
        $fell(MEM.cs_n) && MEM.we_n;
    endsequence
    sequence s_rd_body;
        (!MEM.cs_n && !MEM.oe_n && MEM.we_n) [*8] ##1 (!MEM.cs_n) [*2];
    endsequence
    sequence s_wr_start;
        $fell(MEM.we_n);
    endsequence
    a_we_in_cs: assert property (!MEM.we_n |-> !MEM.cs_n)
        else $error("write strobe low outside chip select");
    a_lane_select: assert property (!MEM.cs_n |-> {MEM.upper_byte_n, MEM.lower_byte_n} == ~last_be)
        else $error("lane selects differ from request");
    // dummy reads during init may use their own address
    a_addr_hold: assert property ($changed(MEM.addr) |-> !$past(INIT_DONE, 2) ||
        $past(REQ_VALID && REQ_READY) || $past(REQ_VALID && REQ_READY, 2))
        else $error("address moved without a new request");
    a_sleep_quiet: assert property (!MEM.sleep_n |-> MEM.cs_n && MEM.we_n)
        else $error("access while in power-down");
    a_pwrup_wait: assert property ($fell(MEM.cs_n) |-> up_cnt >= PWRUP_CYCLES)
        else $error("chip select low before power-up wait");
    a_dummy_reads: assert property ($rose(INIT_DONE) |-> rd_cnt >= 2'h2)
        else $error("init done before two reads");
    a_ready_init: assert property (REQ_READY |-> INIT_DONE)
        else $error("ready before init done");
    a_read_cycle: assert property (s_rd_start |-> s_rd_body)
        else $error("read shorter than a full cycle");
    a_wr_pulse: assert property (s_wr_start |-> (!MEM.we_n && !MEM.cs_n && MEM.oe_n) [*7])
        else $error("write pulse too short");
    a_run_limit: assert property (!MEM.cs_n |-> run_cnt <= psc_pkg::RUN_CYC)
        else $error("write run exceeds refresh limit");
endmodule

bind psc_host psc_host_assertions #(.PWRUP_CYCLES(PWRUP_CYCLES)) chk (
    .CLK(CLK), .RST_B(RST_B), .REQ(REQ), .REQ_VALID(REQ_VALID),
    .REQ_READY(REQ_READY), .INIT_DONE(INIT_DONE), .MEM(MEM)
);

// ### sim/psc_mem_model.sv
// behavioural pseudo-static memory on the far side of the controller
// assumes the bench resolves the shared data bus
module psc_mem_model (
    input wire psc_pkg::psc_pins_t pins, // control pins
    input wire logic [15:0] dq_in, // bus level
    output logic [15:0] dq_out // model drive
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [64];
    logic [15:0] last;
    logic [15:0] word;
    logic rd_on;
    logic rd_ok;
    logic wr_on;
    assign rd_on = !pins.cs_n && !pins.oe_n && pins.we_n && pins.sleep_n;
    // no wait signal: data appears once the access has lasted the access time
    always @(rd_on) begin
        rd_ok = 1'b0;
        if (rd_on) begin
            #100;
            rd_ok = rd_on;
        end
    end
    assign wr_on = !pins.cs_n && !pins.we_n && pins.sleep_n;
    assign word = mem[pins.addr[5:0]];
    initial begin
        foreach (mem[i]) mem[i] = 16'h0000;
        last = 16'h0000;
    end
    always @(posedge rd_ok) last = word;
    // floating lanes show the inverse of the last value
    always_comb begin
        dq_out = ~last;
        if (rd_on && rd_ok) begin
            if (!pins.upper_byte_n) dq_out[15:8] = word[15:8];
            if (!pins.lower_byte_n) dq_out[7:0] = word[7:0];
        end
    end
    // store at the first rise of chip select or strobe
    always @(negedge wr_on) begin
        if (!pins.upper_byte_n) mem[pins.addr[5:0]][15:8] = dq_in[15:8];
        if (!pins.lower_byte_n) mem[pins.addr[5:0]][7:0] = dq_in[7:0];
    end
endmodule

// ### sim/tb_top.sv
// self-checking bench for the memory host controller
// assumes the design, the checker and the device model compile first
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PW = 20;
    logic CLK = 1'h0;
    logic RST_B = 1'h0;
    psc_pkg::psc_req_t REQ = '0;
    logic REQ_VALID = 1'h0;
    logic SLEEP_REQ = 1'h0;
    logic REQ_READY;
    logic RSP_VALID;
    logic INIT_DONE;
    logic MEM_DQ_OE_N;
    logic [15:0] RSP_RDATA;
    logic [15:0] MEM_DQ_O;
    logic [15:0] dev_dq;
    logic [15:0] dq_bus;
    psc_pkg::psc_pins_t MEM;
    int err_count = 0;
    int cmp_count = 0;
    int seed = 32'h65C1;
    logic [15:0] shadow [64];
    logic [15:0] rd;
    int we_w [$];
    int we_len = 0;
    int gap = 0;
    int max_gap = 0;
    always #5 CLK = ~CLK;
    assign dq_bus = MEM_DQ_OE_N ? dev_dq : MEM_DQ_O;
    psc_host #(.PWRUP_CYCLES(PW)) uut (
        .CLK(CLK), .RST_B(RST_B), .REQ(REQ), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
        .RSP_RDATA(RSP_RDATA), .RSP_VALID(RSP_VALID), .INIT_DONE(INIT_DONE), .SLEEP_REQ(SLEEP_REQ),
        .MEM(MEM), .MEM_DQ_I(dq_bus), .MEM_DQ_O(MEM_DQ_O), .MEM_DQ_OE_N(MEM_DQ_OE_N)
    );
    psc_mem_model dev (.pins(MEM), .dq_in(dq_bus), .dq_out(dev_dq));
    // strobe widths and chip-select gaps
    always @(negedge CLK) begin
        if (MEM.we_n === 1'h0) we_len++;
        else if (we_len != 0) begin
            we_w.push_back(we_len);
            we_len = 0;
        end
        if (MEM.cs_n === 1'h0) begin
            if (gap > max_gap) max_gap = gap;
            gap = 0;
        end else gap++;
    end
    // ********
    // tasks
    // ********
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("counts: compares=%0d mismatches=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic hang;
        err_count++;
        close_out();
    endtask
    task automatic wait_init(output int t);
        t = 0;
        do begin
            @(negedge CLK);
            t++;
            if (t > 500) hang();
            if (INIT_DONE !== 1'h1) check(REQ_READY, 1'h0);
        end while (INIT_DONE !== 1'h1);
    endtask
    task automatic access(input logic wr, input logic [20:0] a, input logic [15:0] d, input logic [1:0] be);
        int n;
        n = 0;
        @(posedge CLK);
        REQ_VALID <= 1'h1;
        REQ <= '{wr, a, d, be};
        do begin
            @(negedge CLK);
            n++;
            if (n > 200) hang();
        end while (REQ_READY !== 1'h1);
        @(posedge CLK);
        REQ_VALID <= 1'h0;
        n = 0;
        do begin
            @(negedge CLK);
            n++;
            if (n > 40) hang();
        end while (RSP_VALID !== 1'h1);
        rd = RSP_RDATA;
    endtask
    function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] n, input logic [1:0] be);
        merge = o;
        if (be[1]) merge[15:8] = n[15:8];
        if (be[0]) merge[7:0] = n[7:0];
    endfunction
    // ********
    // main sequence
    // ********
    initial begin
        int t;
        logic [20:0] a;
        logic [15:0] d;
        logic [1:0] be;
        foreach (shadow[i]) shadow[i] = 16'h0000;
        repeat (2) @(posedge CLK);
        @(negedge CLK);
        check(REQ_READY, 1'h0);
        check(MEM.cs_n, 1'h1);
        check(MEM_DQ_OE_N, 1'h1);
        @(posedge CLK);
        RST_B <= 1'h1;
        wait_init(t);
        check(t >= PW + 2 * psc_pkg::RD_LEN, 1'h1);
        check(REQ_READY, 1'h1);
        $display("test init done");
        for (int i = 0; i < 40; i++) begin
            a = 21'($random(seed));
            d = 16'($random(seed));
            be = i < 4 ? i[1:0] : 2'($random(seed));
            access(1'h1, a, d, be);
            shadow[a[5:0]] = merge(shadow[a[5:0]], d, be);
            if (i == 0) max_gap = 0;
        end
        check(we_w[0], psc_pkg::WP_FAST_CYC);
        check(we_w[20], psc_pkg::WP_SLOW_CYC);
        check(max_gap >= 10, 1'h1);
        $display("test write burst done");
        for (int i = 0; i < 64; i++) begin
            access(1'h0, 21'(i), 16'h0000, 2'h3);
            check(rd, shadow[i]);
        end
        $display("test read back done");
        @(posedge CLK);
        SLEEP_REQ <= 1'h1;
        repeat (5) @(negedge CLK);
        check(MEM.sleep_n, 1'h0);
        check(MEM.cs_n, 1'h1);
        check(INIT_DONE, 1'h0);
        check(REQ_READY, 1'h0);
        @(posedge CLK);
        SLEEP_REQ <= 1'h0;
        wait_init(t);
        check(t >= PW + 2 * psc_pkg::RD_LEN, 1'h1);
        d = 16'($random(seed));
        access(1'h1, 21'h000005, d, 2'h3);
        access(1'h0, 21'h000005, 16'h0000, 2'h3);
        check(rd, d);
        $display("test sleep done");
        close_out();
    end
endmodule
